// File: design/state_stream_framer.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Stream bit starts/stops continuous packets
// - Poll strobe sends one packet unless a streamed packet start absorbs it
// - Protocol register reads version 2
// - Words go out low byte first
// - Each frame carries four-byte state word
// - Bit 2 toggles per line zero crossing
// - Bit 11 shows ramp running
// - Bit 12 toggles on ramp start/repeat
// - Bits 15-18 carry averaging exponent
// - Bit 19 shows pulse running
// - Bit 20 toggles per pulse edge
// - Bit 21 toggles on pulse start/repeat
// - Bit 22 shows arbitrary running
// - Bit 23 toggles on arbitrary start/repeat
// - Footer byte bits 2,3 record overloads
// - Exponent follows last averaging setting
module state_stream_framer (
  // Clock and reset
  input  wire logic                     CLOCK_I,
  input  wire logic                     RSTN_I,
  // APB slave
  input  wire logic                     PSEL_I,
  input  wire logic                     PENABLE_I,
  input  wire logic                     PWRITE_I,
  input  wire logic [7:0]               PADDR_I,
  input  wire logic [31:0]              PWDATA_I,
  output logic      [31:0]              PRDATA_O,
  output logic                          PREADY_O,
  output logic                          PSLVERR_O,
  // Instrument events, asynchronous to this clock
  input  wire framer_pkg::inst_event_type EVENTS_I,
  // Byte stream towards the host link
  output framer_pkg::byte_beat_type     TX_BEAT_O,
  output logic                          TX_VALID_O,
  input  wire logic                     TX_READY_I,
  output logic                          BUSY_O
);
  import framer_pkg::*;

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  inst_event_type ev_meta_reg;   // First stage, read only by second
  inst_event_type ev_sync_reg;   // Second stage
  inst_event_type ev_prev_reg;   // Delayed copy for edge detection
  inst_event_type ev_rise;       // Rising edges of pulse-type events

  // Pulse events must stay high and low for two clocks each, or an
  // edge can fall between samples and be lost
  // Two flops before any use; a third stage finds edges
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ev_meta_reg <= '0;
      ev_sync_reg <= '0;
      ev_prev_reg <= '0;
    end else begin
      ev_meta_reg <= EVENTS_I;
      ev_sync_reg <= ev_meta_reg;
      ev_prev_reg <= ev_sync_reg;
    end
  end

  assign ev_rise = ev_sync_reg & ~ev_prev_reg;

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic            stream_en_reg;   // Continuous streaming on
  logic            poll_pend_reg;   // One packet requested
  logic [3:0]      avg_exp_reg;     // Averaging exponent
  logic [7:0]      frames_reg;      // Data frames per packet
  logic            apb_write;       // Write access phase
  logic            poll_take;       // Framer accepts pending poll

  assign apb_write = PSEL_I & PENABLE_I & PWRITE_I;

  // Write access phase aimed at one register offset; shared by every
  // register below so the decode cannot drift between them
  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] offset);
    return wr && (addr == offset);
  endfunction : wr_hit

  // Control bits from software
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      stream_en_reg <= 1'b0;
    end else if (wr_hit(apb_write, PADDR_I, ADDR_CTRL)) begin
      stream_en_reg <= PWDATA_I[CTRL_STREAM_BIT];
    end
  end

  // Poll request: a new write wins over the framer taking the old one
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      poll_pend_reg <= 1'b0;
    end else if (wr_hit(apb_write, PADDR_I, ADDR_CTRL) && PWDATA_I[CTRL_POLL_BIT]) begin
      poll_pend_reg <= 1'b1;
    end else if (poll_take) begin
      poll_pend_reg <= 1'b0;
    end
  end

  // Averaging exponent, values above the maximum are clamped
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      avg_exp_reg <= AVG_RESET;
    end else if (wr_hit(apb_write, PADDR_I, ADDR_AVG)) begin
      avg_exp_reg <= (PWDATA_I[3:0] > AVG_MAX) ? AVG_MAX : PWDATA_I[3:0];
    end
  end

  // Frames per packet; zero is raised to one so a packet always has a frame
  // The count is taken at packet start; a write mid-packet applies next time
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      frames_reg <= FRAMES_RESET;
    end else if (wr_hit(apb_write, PADDR_I, ADDR_FRAMES)) begin
      frames_reg <= (PWDATA_I[7:0] == 8'h00) ? 8'h01 : PWDATA_I[7:0];
    end
  end

  // ------------------------------------------------------------------
  // Live instrument state word
  // ------------------------------------------------------------------
  logic            line_tog_reg;    // Line sync toggle
  logic            ramp_tog_reg;    // Ramp sync toggle
  logic            pedge_tog_reg;   // Pulse edge toggle
  logic            psync_tog_reg;   // Pulse sync toggle
  logic            arb_tog_reg;     // Arbitrary sync toggle
  logic [31:0]     state_word;      // Assembled word

  // Toggles flip on the synchronised event edges
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      line_tog_reg  <= 1'b0;
      ramp_tog_reg  <= 1'b0;
      pedge_tog_reg <= 1'b0;
      psync_tog_reg <= 1'b0;
      arb_tog_reg   <= 1'b0;
    end else begin
      line_tog_reg  <= line_tog_reg  ^ ev_rise.line_zc;
      ramp_tog_reg  <= ramp_tog_reg  ^ ev_rise.ramp_sync;
      pedge_tog_reg <= pedge_tog_reg ^ ev_rise.pulse_edge;
      psync_tog_reg <= psync_tog_reg ^ ev_rise.pulse_sync;
      arb_tog_reg   <= arb_tog_reg   ^ ev_rise.arb_sync;
    end
  end

  // Run levels appear two clocks after the pin, as synchronised
  // Unlisted and internal positions stay zero
  always_comb begin
    state_word                   = '0;
    state_word[ST_LINE_BIT]      = line_tog_reg;
    state_word[ST_RAMP_RUN_BIT]  = ev_sync_reg.ramp_run;
    state_word[ST_RAMP_SYN_BIT]  = ramp_tog_reg;
    state_word[ST_AVG_LSB +: 4]  = avg_exp_reg;
    state_word[ST_PULSE_RUN_BIT] = ev_sync_reg.pulse_run;
    state_word[ST_PULSE_EDG_BIT] = pedge_tog_reg;
    state_word[ST_PULSE_SYN_BIT] = psync_tog_reg;
    state_word[ST_ARB_RUN_BIT]   = ev_sync_reg.arb_run;
    state_word[ST_ARB_SYN_BIT]   = arb_tog_reg;
  end

  // ------------------------------------------------------------------
  // Packet framer
  // ------------------------------------------------------------------
  frame_state_type state_reg;       // Framer state
  logic [31:0]     word_reg;        // State word being sent
  logic [1:0]      byte_idx_reg;    // Byte within word
  logic [7:0]      frame_cnt_reg;   // Frames left after current
  logic            ovl_e_reg;       // Voltage overload this packet
  logic            ovl_i_reg;       // Current overload this packet
  logic            buf_in_ready;    // Buffer accepts a beat
  logic            push;            // Beat enters the buffer
  byte_beat_type   push_beat;       // Beat offered to the buffer
  logic            start_pkt;       // New packet begins

  // A packet starts only from idle, so streamed packets follow one another
  // with one idle cycle between a footer and the next frame
  assign start_pkt = (state_reg == S_IDLE) && (stream_en_reg || poll_pend_reg);
  // Any packet start consumes a pending poll, so a poll made while
  // streaming is absorbed instead of adding a packet after stop
  assign poll_take = start_pkt;
  assign push      = (state_reg != S_IDLE) && buf_in_ready;

  // Beat offered: state word low byte first, then the overload footer
  always_comb begin
    push_beat = '0;
    if (state_reg == S_FOOTER) begin
      push_beat.last            = 1'b1;
      push_beat.data[OVL_E_BIT] = ovl_e_reg;
      push_beat.data[OVL_I_BIT] = ovl_i_reg;
    end else begin
      push_beat.data = word_reg[byte_idx_reg * 8 +: 8];
    end
  end

  // Sequence: frames of four bytes, then one footer byte
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_reg     <= S_IDLE;
      word_reg      <= '0;
      byte_idx_reg  <= '0;
      frame_cnt_reg <= '0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (start_pkt) begin
            state_reg     <= S_FRAME;
            word_reg      <= state_word;
            byte_idx_reg  <= '0;
            frame_cnt_reg <= frames_reg - 8'h01;
          end
        end
        S_FRAME: begin
          if (push) begin
            if (byte_idx_reg != WORD_BYTES) begin
              byte_idx_reg <= byte_idx_reg + 2'h1;
            end else if (frame_cnt_reg != 8'h00) begin
              byte_idx_reg  <= '0;
              word_reg      <= state_word;
              frame_cnt_reg <= frame_cnt_reg - 8'h01;
            end else begin
              state_reg <= S_FOOTER;
            end
          end
        end
        S_FOOTER: begin
          if (push) begin
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // Overload records restart with each packet and are sticky inside it
  // An overload seen only during footer cycles or idle cycles before the start cycle is not recorded
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ovl_e_reg <= 1'b0;
      ovl_i_reg <= 1'b0;
    end else if (start_pkt) begin
      ovl_e_reg <= ev_sync_reg.ovl_e;
      ovl_i_reg <= ev_sync_reg.ovl_i;
    end else if (state_reg == S_FRAME) begin
      ovl_e_reg <= ovl_e_reg | ev_sync_reg.ovl_e;
      ovl_i_reg <= ovl_i_reg | ev_sync_reg.ovl_i;
    end
  end

  // ------------------------------------------------------------------
  // Two-entry output buffer
  // ------------------------------------------------------------------
  byte_beat_type   buf_mem [2];     // Storage
  logic            wr_ptr_reg;      // Write slot
  logic            rd_ptr_reg;      // Read slot
  logic [1:0]      count_reg;       // Entries held
  logic            pop;             // Beat leaves the buffer

  // Two entries let the framer push while the receiver takes the older
  // beat, so a single stall cycle costs no throughput
  assign buf_in_ready = (count_reg != 2'h2);
  assign pop          = TX_VALID_O && TX_READY_I;
  assign TX_VALID_O   = (count_reg != 2'h0);
  assign TX_BEAT_O    = buf_mem[rd_ptr_reg];

  // Storage write; a stall by the receiver holds the framer, not drops
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
    end else if (push) begin
      buf_mem[wr_ptr_reg] <= push_beat;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  assign BUSY_O = (state_reg != S_IDLE) || TX_VALID_O;

  // ------------------------------------------------------------------
  // APB read side
  // ------------------------------------------------------------------
  logic [31:0]     rd_mux;          // Selected read value
  logic            addr_hit;        // Address is mapped

  // Read decode; unmapped addresses answer with an error
  always_comb begin
    rd_mux   = '0;
    addr_hit = 1'b1;
    case (PADDR_I)
      ADDR_CTRL:   rd_mux = {30'h0000_0000, poll_pend_reg, stream_en_reg};
      ADDR_STATUS: rd_mux = {28'h000_0000, count_reg, (state_reg != S_IDLE), BUSY_O};
      ADDR_PROTO:  rd_mux = PROTO_VERSION;
      ADDR_AVG:    rd_mux = {28'h000_0000, avg_exp_reg};
      ADDR_FRAMES: rd_mux = {24'h00_0000, frames_reg};
      ADDR_STATE:  rd_mux = state_word;
      default:     addr_hit = 1'b0;
    endcase
  end

  // Read data is latched in the setup phase; zero-wait answer
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PRDATA_O <= '0;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      PRDATA_O <= rd_mux;
    end
  end

  // Ready is tied high, so every access ends at its first access-phase edge
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_hit;

endmodule : state_stream_framer

`default_nettype wire

// File: dv/framer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module framer_properties
  import framer_pkg::*;
(
  // Clock and reset
  input wire logic                CLOCK_I,
  input wire logic                RSTN_I,
  // APB side
  input wire logic                PSEL_I,
  input wire logic                PENABLE_I,
  input wire logic                PWRITE_I,
  input wire logic [7:0]          PADDR_I,
  input wire logic [31:0]         PWDATA_I,
  input wire logic [31:0]         PRDATA_O,
  input wire logic                PREADY_O,
  input wire logic                PSLVERR_O,
  // Byte stream
  input wire byte_beat_type       TX_BEAT_O,
  input wire logic                TX_VALID_O,
  input wire logic                TX_READY_I,
  input wire logic                BUSY_O
);
  // ------------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);
  // Read access phase at one address
  sequence s_rd(logic [7:0] a);
    PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == a;
  endsequence
  // Stream enable written while the framer is idle
  sequence s_go;
    PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == ADDR_CTRL && PWDATA_I[0] && !BUSY_O;
  endsequence
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  a_proto_read: assert property (s_rd(ADDR_PROTO) |-> PRDATA_O == PROTO_VERSION)
    else $error("protocol read wrong");
  a_start_lat: assert property (s_go |-> ##[1:3] TX_VALID_O)
    else $error("stream did not start");
  a_beat_hold: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_BEAT_O))
    else $error("stalled beat changed");
  a_footer_resv: assert property (TX_VALID_O && TX_BEAT_O.last
    |-> TX_BEAT_O.data[7:4] == 4'h0 && TX_BEAT_O.data[1:0] == 2'h0)
    else $error("footer reserved bits set");
  a_state_resv: assert property (s_rd(ADDR_STATE) |-> PRDATA_O[1:0] == 2'h0
    && PRDATA_O[10:3] == 8'h00 && PRDATA_O[14:13] == 2'h0
    && PRDATA_O[31:24] == 8'h00 && PRDATA_O[18:15] <= AVG_MAX)
    else $error("state word reserved bits set");
  a_busy_valid: assert property (TX_VALID_O |-> BUSY_O)
    else $error("beat without busy");
  a_unmapped_err: assert property (PSEL_I && PENABLE_I && PADDR_I > ADDR_STATE |-> PSLVERR_O)
    else $error("unmapped access not refused");
  a_ready_high: assert property (PSEL_I |-> PREADY_O)
    else $error("wait state inserted");
endmodule : framer_properties
// Watches every framer instance
bind state_stream_framer framer_properties i_framer_properties (
  .CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TX_BEAT_O(TX_BEAT_O),
  .TX_VALID_O(TX_VALID_O), .TX_READY_I(TX_READY_I), .BUSY_O(BUSY_O));
`default_nettype wire

// File: dv/host_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_rx_model
  import framer_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rstn_i,
  // Byte stream from the framer
  input  wire byte_beat_type beat_i,
  input  wire logic          valid_i,
  input  wire logic          slow_i,   // Accept only one cycle in four
  output logic               ready_o
);
  byte_beat_type rx_q[$];              // Bytes in arrival order
  logic [1:0]    cnt_reg;              // Stall pacing
  // Free running pacing counter
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) cnt_reg <= 2'h0;
    else cnt_reg <= cnt_reg + 2'h1;
  end
  // Slow mode keeps the buffer full so the framer must stall
  assign ready_o = !slow_i || cnt_reg == 2'h0;
  // Take a byte at each handshake edge; word order is rebuilt by the reader
  always @(posedge clk_i) begin
    if (rstn_i && valid_i && ready_o) rx_q.push_back(beat_i);
  end
endmodule : host_rx_model
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import framer_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic           clk = 1'b0;
  logic           rstn, psel, penable, pwrite, pready, pslverr, err;
  logic           tx_valid, tx_ready, busy, slow;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, rd;
  logic [31:0]    exp_st = 32'h0000_0000;   // Expected state word
  inst_event_type ev;
  byte_beat_type  beat;
  int             fails = 0;
  int             tests_run = 0;
  always #50 clk = ~clk;
  state_stream_framer i_state_stream_framer (.CLOCK_I(clk), .RSTN_I(rstn), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .EVENTS_I(ev),
    .TX_BEAT_O(beat), .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready), .BUSY_O(busy));
  host_rx_model i_host_rx_model (.clk_i(clk), .rstn_i(rstn), .beat_i(beat),
    .valid_i(tx_valid), .slow_i(slow), .ready_o(tx_ready));
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One APB transfer; waits for pready, never assumes a latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // Pop one packet and judge its words and footer
  task automatic get_pkt(input int frames, input logic [7:0] foot);
    logic [31:0] w;
    byte_beat_type b;
    for (int i = 0; i < 3000 && i_host_rx_model.rx_q.size() < frames * 4 + 1; i++) @(posedge clk);
    chk("packet bytes", 32'h0000_0001, {31'h0, i_host_rx_model.rx_q.size() >= frames * 4 + 1});
    if (i_host_rx_model.rx_q.size() < frames * 4 + 1) return;
    for (int f = 0; f < frames; f++) begin
      for (int k = 0; k < 4; k++) begin
        b = i_host_rx_model.rx_q.pop_front();
        w[k*8 +: 8] = b.data;  // Low byte arrives first
        chk("frame last", 32'h0000_0000, {31'h0, b.last});
      end
      chk("frame word", exp_st, w);
    end
    b = i_host_rx_model.rx_q.pop_front();
    chk("footer", {23'h00_0000, 1'b1, foot}, {23'h00_0000, b});
  endtask : get_pkt
  task automatic t_regs;
    apb(1'b0, ADDR_PROTO, 32'h0000_0000);
    chk("proto", PROTO_VERSION, rd);
    apb(1'b0, ADDR_FRAMES, 32'h0000_0000);
    chk("frames reset", {24'h00_0000, FRAMES_RESET}, rd);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
  endtask : t_regs
  task automatic t_avg;
    apb(1'b1, ADDR_AVG, 32'h0000_0009);
    apb(1'b0, ADDR_STATE, 32'h0000_0000);
    exp_st[18:15] = AVG_MAX;
    chk("state clamp", exp_st, rd);
    apb(1'b1, ADDR_AVG, 32'h0000_0003);
    apb(1'b0, ADDR_STATE, 32'h0000_0000);
    exp_st[18:15] = 4'h3;
    chk("state avg", exp_st, rd);
  endtask : t_avg
  // Toggle events first, then run levels, each seen in the live word
  task automatic t_events;
    int eb[8] = '{9, 7, 5, 4, 2, 8, 6, 3};
    int sb[8] = '{2, 12, 20, 21, 23, 11, 19, 22};
    for (int i = 0; i < 8; i++) begin
      ev[eb[i]] <= 1'b1;
      repeat (3) @(posedge clk);
      if (i < 5) ev[eb[i]] <= 1'b0;
      repeat (5) @(posedge clk);
      exp_st[sb[i]] = 1'b1;
      apb(1'b0, ADDR_STATE, 32'h0000_0000);
      chk("state event", exp_st, rd);
    end
  endtask : t_events
  task automatic t_poll;
    apb(1'b1, ADDR_FRAMES, 32'h0000_0002);
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    ev.ovl_e <= 1'b1;
    repeat (4) @(posedge clk);
    ev.ovl_e <= 1'b0;
    get_pkt(2, 8'h04);
    repeat (40) @(posedge clk);
    chk("poll extra", 32'h0000_0000, i_host_rx_model.rx_q.size());
    apb(1'b0, ADDR_CTRL, 32'h0000_0000);
    chk("poll cleared", 32'h0000_0000, rd);
  endtask : t_poll
  // Stalling host; overload only in the first packet; the poll sent
  // with the start must be absorbed, leaving nothing after stop
  task automatic t_stream;
    slow <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    ev.ovl_i <= 1'b1;
    repeat (6) @(posedge clk);
    ev.ovl_i <= 1'b0;
    get_pkt(2, 8'h08);
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    get_pkt(2, 8'h00);
    for (int i = 0; i < 500 && busy !== 1'b0; i++) @(posedge clk);
    repeat (40) @(posedge clk);
    chk("stream stop", 32'h0000_0000, i_host_rx_model.rx_q.size());
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("status idle", 32'h0000_0000, rd);
  endtask : t_stream
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; slow = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; ev = '0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_regs;
    t_avg;
    t_events;
    t_poll;
    t_stream;
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_sim;
  end
endmodule : tb
`default_nettype wire

// File: pkg/framer_pkg.sv
package framer_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00;  // Stream enable, poll strobe
  localparam logic [7:0] ADDR_STATUS  = 8'h04;  // Framer state, read only
  localparam logic [7:0] ADDR_PROTO   = 8'h08;  // Protocol version, read only
  localparam logic [7:0] ADDR_AVG     = 8'h0C;  // Averaging exponent
  localparam logic [7:0] ADDR_FRAMES  = 8'h10;  // Frames per packet
  localparam logic [7:0] ADDR_STATE   = 8'h14;  // Live state word, read only

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CTRL_STREAM_BIT  = 0;
  localparam int CTRL_POLL_BIT    = 1;
  localparam int ST_LINE_BIT      = 2;
  localparam int ST_RAMP_RUN_BIT  = 11;
  localparam int ST_RAMP_SYN_BIT  = 12;
  localparam int ST_AVG_LSB       = 15;
  localparam int ST_PULSE_RUN_BIT = 19;
  localparam int ST_PULSE_EDG_BIT = 20;
  localparam int ST_PULSE_SYN_BIT = 21;
  localparam int ST_ARB_RUN_BIT   = 22;
  localparam int ST_ARB_SYN_BIT   = 23;
  localparam int OVL_E_BIT        = 2;
  localparam int OVL_I_BIT        = 3;

  // ------------------------------------------------------------------
  // Values and reset defaults
  // ------------------------------------------------------------------
  localparam logic [31:0] PROTO_VERSION = 32'h0000_0002;
  localparam logic [3:0]  AVG_RESET     = 4'h0;
  localparam logic [3:0]  AVG_MAX       = 4'h8;
  localparam logic [7:0]  FRAMES_RESET  = 8'h04;
  localparam logic [1:0]  WORD_BYTES    = 2'h3;   // Last byte index of a word

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        last;   // Final byte of a packet
    logic [7:0]  data;
  } byte_beat_type;

  typedef struct packed {
    logic line_zc;    // Power line zero crossing pulse
    logic ramp_run;   // Ramp generator running level
    logic ramp_sync;  // Ramp start or repeat pulse
    logic pulse_run;  // Pulse generator running level
    logic pulse_edge; // Pulse edge pulse
    logic pulse_sync; // Pulse start or repeat pulse
    logic arb_run;    // Arbitrary generator running level
    logic arb_sync;   // Arbitrary start or repeat pulse
    logic ovl_e;      // Voltage overload level
    logic ovl_i;      // Current overload level
  } inst_event_type;

  typedef enum {S_IDLE, S_FRAME, S_FOOTER} frame_state_type;

endpackage : framer_pkg
